// ### rie_core.sv
// rie_core.sv: top of the reader command interpreter: register file,
// direct commands, interrupt cause and the shared 24 byte queue.
// Assumes decoder and transmitter strobes are on mclk; pins are not.
`include "rie_consts.svh"
module rie_core
  import rie_pkg::*;
#(
  parameter int FIFO_DEPTH = `RIE_FIFO_DEPTH
) (
  input  wire logic       mclk,          // system clock, 250 MHz
  input  wire logic       rst,           // async reset, high
  input  wire logic       ce,            // clock enable
  input  wire logic       chip_en,       // chip enable pin, low sleeps
  input  wire logic       spi_sclk,      // serial clock pin
  input  wire logic       spi_cs_n,      // frame select pin, low active
  input  wire logic       spi_mosi,      // serial data in pin
  output logic            spi_miso_o,    // serial data out
  output logic            spi_miso_oe,   // serial data out enable
  input  wire logic       rx_byte_valid, // decoder byte strobe
  input  wire logic [7:0] rx_byte,       // decoder byte
  input  wire logic       rx_done,       // end of reception strobe
  input  wire logic [1:0] rx_kind,       // reply kind at rx_done
  input  wire logic [1:0] rx_status,     // reply result at rx_done
  input  wire logic       tx_done,       // end of transmission strobe
  output logic            tx_start,      // transmit request pulse
  output logic [7:0]      tx_cmd,        // command that started transmit
  output logic            rx_enable,     // receiver enable level
  output logic            irq            // interrupt pin, high active
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(FIFO_DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

  // ========================================================================
  // serial slave
  rie_link_if link ();
  rie_spi_slave u_spi (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .sclk    (spi_sclk),
    .cs_n    (spi_cs_n),
    .mosi    (spi_mosi),
    .miso_o  (spi_miso_o),
    .miso_oe (spi_miso_oe),
    .link    (link)
  );

  // ========================================================================
  // chip enable synchroniser, low level clears the core
  logic en_s1;
  logic awake;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_s1 <= 1'b0;
      awake <= 1'b0;
    end else if (ce) begin
      en_s1 <= chip_en;
      awake <= en_s1;
    end
  end

  // ========================================================================
  // access decode
  rie_port_state_t ps_reg;
  logic [5:0]      addr_reg;
  logic [7:0]      rx_ctrl_reg;
  logic [7:0]      cause_reg;
  logic            tx_blocked_reg;
  logic            hold_reg;
  logic            last_rn16_reg;
  logic [7:0]      fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   rd_ptr;
  logic [CW-1:0]   count;
  logic            q_shown_reg;
  logic            peek_ok;
  logic [PW-1:0]   rd_step;
  logic [PW-1:0]   peek_ptr;

  logic       b_cmd;
  logic       rd_hit;
  logic       wr_hit;
  logic       cmd_hit;
  logic [5:0] acc_addr;
  logic [5:0] addr_inc;
  logic       is_tx_cmd;
  logic       hold_cmd;

  assign b_cmd    = link.byte_data[`RIE_CMD_BIT];
  assign acc_addr = link.byte_first ? link.byte_data[5:0] : addr_reg;
  assign addr_inc = (acc_addr == `RIE_ADDR_FIFO) ? acc_addr
                                                 : acc_addr + 6'h01;
  assign cmd_hit  = awake & link.byte_valid & link.byte_first & b_cmd;
  assign rd_hit   = awake & link.byte_valid &
                    (link.byte_first ? (~b_cmd &
                                        link.byte_data[`RIE_READ_BIT])
                                     : (ps_reg == RIE_PS_READ));
  assign wr_hit   = awake & link.byte_valid & ~link.byte_first &
                    (ps_reg == RIE_PS_WRITE);
  assign is_tx_cmd = (link.byte_data >= `RIE_CMD_TX_FIRST &&
                      link.byte_data <= `RIE_CMD_TX_LAST) ||
                     link.byte_data == `RIE_CMD_REQ_HANDLE;
  assign hold_cmd  = cmd_hit & (link.byte_data == `RIE_CMD_RX_HOLD);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ps_reg   <= RIE_PS_IDLE;
      addr_reg <= 6'h00;
    end else if (ce) begin
      if (!awake) begin
        ps_reg   <= RIE_PS_IDLE;
        addr_reg <= 6'h00;
      end else if (link.byte_valid && link.byte_first) begin
        case ({b_cmd, link.byte_data[`RIE_READ_BIT]})
          2'b00: begin
            ps_reg   <= RIE_PS_WRITE;
            addr_reg <= link.byte_data[5:0];
          end
          2'b01: begin
            ps_reg   <= RIE_PS_READ;
            addr_reg <= addr_inc;
          end
          default: ps_reg <= RIE_PS_IDLE;
        endcase
      end else if (rd_hit || wr_hit) begin
        addr_reg <= addr_inc;
      end
    end
  end

  // ========================================================================
  // read data towards the serial slave
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (acc_addr)
      `RIE_ADDR_RX_CTRL: rd_mux = rx_ctrl_reg;
      `RIE_ADDR_CAUSE:   rd_mux = cause_reg;
      `RIE_ADDR_FSTAT:   rd_mux = 8'(count);
      `RIE_ADDR_FIFO:    rd_mux = peek_ok ? fifo_mem[peek_ptr] : 8'h00;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.tx_load <= 1'b0;
      link.tx_data <= 8'h00;
    end else if (ce) begin
      link.tx_load <= rd_hit;
      if (rd_hit) link.tx_data <= rd_mux;
    end
  end

  // ========================================================================
  // receiver control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rx_ctrl_reg <= `RIE_RX_CTRL_RST;
    else if (ce) begin
      if (!awake) rx_ctrl_reg <= `RIE_RX_CTRL_RST;
      else if (wr_hit && acc_addr == `RIE_ADDR_RX_CTRL)
        rx_ctrl_reg <= link.byte_data;
    end
  end

  // ========================================================================
  // queue shared by decoder and host, decoder wins a clash
  logic       push;
  logic       pop;
  logic       flush;
  logic [7:0] push_data;
  assign flush     = cmd_hit & (link.byte_data == `RIE_CMD_FIFO_RST);
  assign push      = awake & (rx_byte_valid |
                     (wr_hit & acc_addr == `RIE_ADDR_FIFO)) &
                     (count != FULL_CNT);
  // queue byte leaves only once the next byte shows it was clocked out,
  // so the prefetch at the last byte of a frame loses nothing
  assign pop       = q_shown_reg & rd_hit & ~link.byte_first &
                     (count != '0);
  assign rd_step   = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
  assign peek_ptr  = pop ? rd_step : rd_ptr;
  assign peek_ok   = pop ? (count > CW'(1)) : (count != '0);
  assign push_data = rx_byte_valid ? rx_byte : link.byte_data;

  always_ff @(posedge mclk) begin
    if (ce && push) fifo_mem[wr_ptr] <= push_data;
  end

  // queue byte sits in the serial shifter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) q_shown_reg <= 1'b0;
    else if (ce) begin
      if (!awake || flush) q_shown_reg <= 1'b0;
      else if (link.byte_valid)
        q_shown_reg <= rd_hit & (acc_addr == `RIE_ADDR_FIFO) & peek_ok;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (!awake || flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (push) wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
        if (pop)  rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
        if (push && !pop) count <= count + 1'b1;
        else if (pop && !push) count <= count - 1'b1;
      end
    end
  end

  // ========================================================================
  // reception results and transmit blocking
  logic rn16_crc;
  assign rn16_crc = rx_done & (rx_kind == `RIE_KIND_RN16) &
                    (rx_status == `RIE_RXST_CRC);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_blocked_reg <= 1'b0;
      hold_reg       <= 1'b0;
      last_rn16_reg  <= 1'b0;
    end else if (ce) begin
      if (!awake) begin
        tx_blocked_reg <= 1'b0;
        hold_reg       <= 1'b0;
        last_rn16_reg  <= 1'b0;
      end else begin
        if (rn16_crc) tx_blocked_reg <= 1'b1;
        if (hold_cmd) hold_reg <= 1'b1;
        else if (cmd_hit && is_tx_cmd) hold_reg <= 1'b0;
        if (rx_done)
          last_rn16_reg <= (rx_kind == `RIE_KIND_RN16) &&
                           (rx_status == `RIE_RXST_OK);
        else if (tx_start) last_rn16_reg <= 1'b0;
      end
    end
  end

  // blocked transmitter keeps the receiver listening
  assign rx_enable = awake & (tx_blocked_reg |
                     ~(hold_reg | rx_ctrl_reg == `RIE_RX_CTRL_HOLD));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_start <= 1'b0;
      tx_cmd   <= 8'h00;
    end else if (ce) begin
      tx_start <= cmd_hit & is_tx_cmd & ~tx_blocked_reg;
      if (cmd_hit && is_tx_cmd && !tx_blocked_reg)
        tx_cmd <= link.byte_data;
    end
  end

  // ========================================================================
  // interrupt cause, set wins over the clear on read
  logic [7:0] cause_set;
  logic [7:0] cause_keep;
  logic       cause_clr;
  assign cause_clr = rd_hit & (acc_addr == `RIE_ADDR_CAUSE);

  always_comb begin
    cause_set = 8'h00;
    if (tx_done && !tx_blocked_reg) cause_set = cause_set | `RIE_CAUSE_TX;
    if (rx_done) begin
      case (rx_status)
        `RIE_RXST_OK:   cause_set = cause_set | `RIE_CAUSE_RX;
        `RIE_RXST_CRC: begin
          if (rx_kind == `RIE_KIND_RN16)
            cause_set = cause_set | `RIE_CAUSE_RX;
          else if (rx_kind == `RIE_KIND_EPC)
            cause_set = cause_set;
          else
            cause_set = cause_set | `RIE_CAUSE_RX |
                        `RIE_CAUSE_ERR;
        end
        default: cause_set = cause_set | `RIE_CAUSE_RX |
                             `RIE_CAUSE_ERR;
      endcase
    end
  end

  always_comb begin
    cause_keep = cause_reg;
    if (hold_cmd && last_rn16_reg)
      cause_keep = cause_reg[7] ? (`RIE_CAUSE_TX | `RIE_CAUSE_RX)
                                : 8'h00;
    else if (cause_clr)
      cause_keep = 8'h00;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cause_reg <= `RIE_CAUSE_RST;
    else if (ce) begin
      if (!awake) cause_reg <= `RIE_CAUSE_RST;
      else cause_reg <= cause_keep | cause_set;
    end
  end

  assign irq = (cause_reg != 8'h00);
endmodule

// ### rie_consts.svh
// rie_consts.svh: offsets, field values, reset values and sizes of the
// reader command interpreter.
// Assumes inclusion by bare name from the package and the design modules.
//
// Overview of operation
// - hold-receiver command after an RN16 reply turns cause into 0x00 or 0xC0.
// - corrupted RN16 with cause 0x40 keeps receiver on, blocks transmit, no 0x80.
// - a corrupted EPC reply sets no cause bit; the cause register keeps its value.
// - after any other corrupted reception the cause register reads 0x41.
`ifndef RIE_CONSTS_SVH
`define RIE_CONSTS_SVH

// ==========================================================================
// register offsets
`define RIE_ADDR_RX_CTRL   6'h03
`define RIE_ADDR_CAUSE     6'h0C
`define RIE_ADDR_FSTAT     6'h0D
`define RIE_ADDR_FIFO      6'h1F

// ==========================================================================
// field values and reset values
`define RIE_RX_CTRL_RST    8'h00
`define RIE_RX_CTRL_HOLD   8'h0A
`define RIE_CAUSE_RST      8'h00
`define RIE_CAUSE_TX       8'h80
`define RIE_CAUSE_RX       8'h40
`define RIE_CAUSE_ERR      8'h01
`define RIE_CMD_BIT        7
`define RIE_READ_BIT       6

// ==========================================================================
// direct commands
`define RIE_CMD_FIFO_RST   8'h8F
`define RIE_CMD_REQ_HANDLE 8'h9F
`define RIE_CMD_TX_FIRST   8'h90
`define RIE_CMD_TX_LAST    8'h92
`define RIE_CMD_RX_HOLD    8'h96

// ==========================================================================
// reception kinds and results from the decoder
`define RIE_KIND_RN16      2'h0
`define RIE_KIND_EPC       2'h1
`define RIE_RXST_OK        2'h0
`define RIE_RXST_CRC       2'h1
`define RIE_RXST_COLL      2'h2

// ==========================================================================
// sizes
`define RIE_FIFO_DEPTH     24

`endif

// ### rie_pkg.sv
// rie_pkg.sv: types of the reader command interpreter.
// Assumes rie_consts.svh is on the include path.
`include "rie_consts.svh"
package rie_pkg;
  typedef enum logic [1:0] {
    RIE_PS_IDLE,
    RIE_PS_WRITE,
    RIE_PS_READ
  } rie_port_state_t;
endpackage

// ### rie_link_if.sv
// rie_link_if.sv: byte link between serial slave and core.
// Assumes both ends run on mclk.
interface rie_link_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       byte_first;
  logic       tx_load;
  logic [7:0] tx_data;
  modport spi  (output byte_valid, byte_data, byte_first,
                input  tx_load, tx_data);
  modport core (input  byte_valid, byte_data, byte_first,
                output tx_load, tx_data);
endinterface

// ### rie_spi_slave.sv
// rie_spi_slave.sv: mode 0 serial slave, bytes in and out.
// Assumes sclk well below a fifth of mclk; pins are asynchronous.
module rie_spi_slave (
  input  wire logic mclk,       // system clock
  input  wire logic rst,        // async reset, high
  input  wire logic ce,         // clock enable
  input  wire logic sclk,       // serial clock pin
  input  wire logic cs_n,       // frame select pin, low active
  input  wire logic mosi,       // serial data in pin
  output logic      miso_o,     // serial data out
  output logic      miso_oe,    // serial data out enable
  rie_link_if.spi   link        // byte link to core
);
  // ========================================================================
  // pin synchronisers
  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  assign pin_in = {mosi, cs_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else if (ce) begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // ========================================================================
  // edge detection
  logic sclk_d;
  logic sel;
  logic rise;
  logic fall;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sclk_d <= 1'b0;
    else if (ce) sclk_d <= sync2[0];
  end
  assign sel  = ~sync2[1];
  assign rise = sel & sync2[0] & ~sclk_d;
  assign fall = sel & ~sync2[0] & sclk_d;

  // ========================================================================
  // receive shifter
  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  logic       first_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt         <= 3'h0;
      rx_shift        <= 8'h00;
      first_reg       <= 1'b1;
      link.byte_valid <= 1'b0;
      link.byte_data  <= 8'h00;
      link.byte_first <= 1'b0;
    end else if (ce) begin
      link.byte_valid <= 1'b0;
      if (!sel) begin
        bit_cnt   <= 3'h0;
        first_reg <= 1'b1;
      end else if (rise) begin
        rx_shift <= {rx_shift[6:0], sync2[2]};
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          link.byte_valid <= 1'b1;
          link.byte_data  <= {rx_shift[6:0], sync2[2]};
          link.byte_first <= first_reg;
          first_reg       <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // transmit shifter, loads the held byte at each byte boundary
  logic [7:0] tx_hold;
  logic [7:0] tx_shift;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_hold  <= 8'h00;
      tx_shift <= 8'h00;
    end else if (ce) begin
      if (link.tx_load) tx_hold <= link.tx_data;
      else if (!sel) tx_hold <= 8'h00;
      if (!sel) tx_shift <= 8'h00;
      else if (fall && bit_cnt == 3'h0) tx_shift <= tx_hold;
      else if (fall) tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end
  assign miso_o  = tx_shift[7];
  assign miso_oe = sel;
endmodule

// ### rie_host_model.sv
// rie_host_model.sv: serial host that frames bytes and works chip enable.
// Assumes mclk at 250 MHz; the bench calls its tasks by hierarchy.
module rie_host_model (
  input  wire logic mclk,     // system clock
  input  wire logic miso_o,   // serial out of dut
  input  wire logic miso_oe,  // its enable
  output logic      sclk,     // serial clock
  output logic      cs_n,     // frame select, low active
  output logic      mosi,     // serial in of dut
  output logic      chip_en   // chip enable pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  // released line shows the inverse of its last bit
  wire  miso = miso_oe ? miso_o : ~last;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
    chip_en = 1'h1;
    last = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ==========================================================
  // bytes and frames, 10 MHz serial clock
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= b[i];
      wt(12);
      sclk <= 1'h1;
      r[i] = miso;
      last <= miso;
      wt(12);
      sclk <= 1'h0;
    end
  endtask
  task automatic frame(input logic [7:0] a, d, input bit two,
                       output logic [7:0] r);
    cs_n <= 1'h0;
    wt(3);
    xfer(a, r);
    if (two) xfer(d, r);
    wt(2);
    cs_n <= 1'h1;
    mosi <= ~mosi;
    wt(6);
  endtask
  // ==========================================================
  // recovery pulse high, low, high on chip enable
  task automatic en_cycle();
    chip_en <= 1'h0;
    wt(8);
    chip_en <= 1'h1;
    wt(6);
  endtask
endmodule

// ### rie_core_chk.sv
// rie_core_chk.sv: port assertions of the reader command interpreter.
// Assumes a bind onto rie_core; one clock, reset async high.
`include "rie_consts.svh"
module rie_core_chk #(
  parameter int FIFO_DEPTH = `RIE_FIFO_DEPTH
) (
  input wire logic       mclk,          // system clock
  input wire logic       rst,           // reset, high
  input wire logic       ce,            // clock enable
  input wire logic       chip_en,       // chip enable pin
  input wire logic       spi_sclk,      // serial clock
  input wire logic       spi_cs_n,      // frame select
  input wire logic       spi_mosi,      // serial in
  input wire logic       spi_miso_o,    // serial out
  input wire logic       spi_miso_oe,   // serial out enable
  input wire logic       rx_byte_valid, // decoder strobe
  input wire logic [7:0] rx_byte,       // decoder byte
  input wire logic       rx_done,       // reception end
  input wire logic [1:0] rx_kind,       // reply kind
  input wire logic [1:0] rx_status,     // reply result
  input wire logic       tx_done,       // transmit end
  input wire logic       tx_start,      // transmit request
  input wire logic [7:0] tx_cmd,        // transmit command
  input wire logic       rx_enable,     // receiver enable
  input wire logic       irq            // interrupt
);
  // ==========================================================
  // helper state
  logic       blk_reg;  // bad rn16 seen since wake
  logic [2:0] en_reg;   // chip enable history
  wire        en_ok = (&en_reg) & chip_en;
  wire        rn_bad = rx_done && rx_kind == `RIE_KIND_RN16
                       && rx_status == `RIE_RXST_CRC;
  wire        epc_bad = rx_done && rx_kind == `RIE_KIND_EPC
                        && rx_status == `RIE_RXST_CRC;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) en_reg <= 3'h0;
    else en_reg <= {en_reg[1:0], chip_en};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) blk_reg <= 1'h0;
    else if (!chip_en) blk_reg <= 1'h0;
    else if (rn_bad && en_ok) blk_reg <= 1'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  AST_TX_PULSE: assert property (tx_start |=> !tx_start)
    else $error("transmit request longer than one cycle");
  AST_TX_IRQ: assert property (tx_done && en_ok && !blk_reg |=> irq)
    else $error("no interrupt after transmit end");
  AST_BLK_NOTX: assert property (blk_reg |-> !tx_start)
    else $error("transmit started while blocked");
  AST_BLK_RXON: assert property (blk_reg |-> rx_enable)
    else $error("receiver off while blocked");
  AST_BLK_NOIRQ: assert property (blk_reg && tx_done && !irq |=> !irq)
    else $error("transmit interrupt while blocked");
  AST_RN16_CRC: assert property (rn_bad && en_ok |=> irq)
    else $error("bad rn16 gave no cause");
  AST_EPC_CRC: assert property (epc_bad && !irq && !tx_done |=> !irq)
    else $error("bad epc gave a cause");
  AST_COLL: assert property (rx_done && rx_status[1] && en_ok |=> irq)
    else $error("collision gave no cause");
  cover property (tx_start);
  cover property (blk_reg && tx_done);
  cover property (epc_bad);
endmodule
bind rie_core rie_core_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .mclk(mclk), .rst(rst), .ce(ce), .chip_en(chip_en),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
  .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
  .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_done(rx_done),
  .rx_kind(rx_kind), .rx_status(rx_status), .tx_done(tx_done),
  .tx_start(tx_start), .tx_cmd(tx_cmd), .rx_enable(rx_enable),
  .irq(irq));

// ### testbench.sv
// testbench.sv: scenarios for the reader command interpreter.
// Assumes rie_host_model plays the host; bench plays the decoder.
`include "rie_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rst, ce, chip_en, sclk, cs_n, mosi, miso_o, miso_oe;
  logic       rx_byte_valid, rx_done, tx_done, tx_start, rx_enable, irq;
  logic [7:0] rx_byte, tx_cmd;
  logic [1:0] rx_kind, rx_status;
  int         failures = 0;
  int         checked = 0;
  int         txn = 0;
  rie_core u_dut (.mclk(mclk), .rst(rst), .ce(ce), .chip_en(chip_en),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_done(rx_done),
    .rx_kind(rx_kind), .rx_status(rx_status), .tx_done(tx_done),
    .tx_start(tx_start), .tx_cmd(tx_cmd), .rx_enable(rx_enable),
    .irq(irq));
  rie_host_model u_host (.mclk(mclk), .miso_o(miso_o),
    .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .chip_en(chip_en));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (tx_start === 1'h1) txn <= txn + 1;
  // ==========================================================
  // shared tasks
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_host.frame({2'h1, a}, 8'h00, 1'h1, r);
    chk(r, e, $sformatf("read %h", a));
  endtask
  task automatic wr(input logic [7:0] a, d, input bit two);
    logic [7:0] r;
    u_host.frame(a, d, two, r);
  endtask
  // decoder strobes: {byte valid, rx done, tx done}
  task automatic dec(input logic [2:0] v, input logic [7:0] b,
                     input logic [1:0] k, s);
    {rx_byte_valid, rx_done, tx_done} <= v;
    rx_byte <= b;
    rx_kind <= k;
    rx_status <= s;
    @(posedge mclk);
    {rx_byte_valid, rx_done, tx_done} <= 3'h0;
    rx_byte <= ~b;
    rx_kind <= ~k;
    @(posedge mclk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(6'h03, `RIE_RX_CTRL_RST);
    rd(6'h0C, `RIE_CAUSE_RST);
    rd(6'h3E, 8'h00);
    chk({7'h00, rx_enable}, 8'h01, "receiver on");
    $display("t_reset done");
  endtask
  task automatic t_tx();
    int n;
    n = txn;
    wr(`RIE_CMD_REQ_HANDLE, 8'h00, 1'h0);
    chk(8'(txn - n), 8'h01, "one request");
    chk(tx_cmd, `RIE_CMD_REQ_HANDLE, "request code");
    dec(3'h1, 8'h00, 2'h0, 2'h0);
    chk({7'h00, irq}, 8'h01, "irq on transmit end");
    wr(`RIE_CMD_FIFO_RST, 8'h00, 1'h0);
    rd(6'h0C, `RIE_CAUSE_TX);
    rd(6'h0C, 8'h00);
    $display("t_tx done");
  endtask
  task automatic t_hold();
    dec(3'h2, 8'h00, `RIE_KIND_RN16, `RIE_RXST_OK);
    wr(`RIE_CMD_RX_HOLD, 8'h00, 1'h0);
    chk({7'h00, rx_enable}, 8'h00, "receiver held");
    rd(6'h0C, 8'h00);
    wr(`RIE_CMD_REQ_HANDLE, 8'h00, 1'h0);
    dec(3'h1, 8'h00, 2'h0, 2'h0);
    dec(3'h2, 8'h00, `RIE_KIND_RN16, `RIE_RXST_OK);
    wr(`RIE_CMD_RX_HOLD, 8'h00, 1'h0);
    rd(6'h0C, 8'hC0);
    wr(`RIE_CMD_REQ_HANDLE, 8'h00, 1'h0);
    wr(8'h03, `RIE_RX_CTRL_HOLD, 1'h1);
    chk({7'h00, rx_enable}, 8'h00, "receiver held by reg");
    rd(6'h03, `RIE_RX_CTRL_HOLD);
    wr(8'h03, 8'h00, 1'h1);
    chk({7'h00, rx_enable}, 8'h01, "receiver released");
    $display("t_hold done");
  endtask
  task automatic t_block();
    int n;
    dec(3'h2, 8'h00, `RIE_KIND_RN16, `RIE_RXST_CRC);
    rd(6'h0C, `RIE_CAUSE_RX);
    n = txn;
    wr(`RIE_CMD_TX_FIRST, 8'h00, 1'h0);
    dec(3'h1, 8'h00, 2'h0, 2'h0);
    chk(8'(txn - n), 8'h00, "transmit blocked");
    chk({7'h00, rx_enable}, 8'h01, "receiver kept on");
    rd(6'h0C, 8'h00);
    u_host.en_cycle();
    for (logic [7:0] c = 8'h90; c <= 8'h92; c++) wr(c, 8'h00, 1'h0);
    chk(8'(txn - n), 8'h03, "transmit after recovery");
    $display("t_block done");
  endtask
  task automatic t_rxerr();
    logic [11:0] tbl [5] = '{12'h500, 12'h941, 12'h241, 12'h741,
                             12'h440};
    int n;
    foreach (tbl[i]) begin
      dec(3'h2, 8'h00, tbl[i][11:10], tbl[i][9:8]);
      rd(6'h0C, tbl[i][7:0]);
    end
    n = txn;
    dec(3'h2, 8'h00, `RIE_KIND_EPC, `RIE_RXST_CRC);
    wr(`RIE_CMD_TX_FIRST, 8'h00, 1'h0);
    chk(8'(txn - n), 8'h01, "round goes on");
    $display("t_rxerr done");
  endtask
  task automatic t_queue();
    dec(3'h4, 8'hA5, 2'h0, 2'h0);
    dec(3'h4, 8'h3C, 2'h0, 2'h0);
    dec(3'h4, 8'hF0, 2'h0, 2'h0);
    rd(6'h0D, 8'h03);
    rd(6'h1F, 8'hA5);
    rd(6'h1F, 8'h3C);
    wr(`RIE_CMD_FIFO_RST, 8'h00, 1'h0);
    rd(6'h0D, 8'h00);
    rd(6'h1F, 8'h00);
    $display("t_queue done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    {rx_byte_valid, rx_done, tx_done} = 3'h0;
    rx_byte = 8'h00;
    rx_kind = 2'h0;
    rx_status = 2'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    repeat (6) @(posedge mclk);
    t_reset();
    t_tx();
    t_hold();
    t_block();
    t_rxerr();
    t_queue();
    stop_test();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule
